// File: hw/module_disable.sv
// Module-disable register bank with pin-change interrupt master gate
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module module_disable #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [module_disable_pkg::PIN_COUNT-1:0] pin_in,
  input wire logic [module_disable_pkg::PIN_COUNT-1:0] rise_enable,
  input wire logic [module_disable_pkg::PIN_COUNT-1:0] fall_enable,
  input wire logic [module_disable_pkg::PIN_COUNT-1:0] flag_clear,
  output logic [module_disable_pkg::PIN_COUNT-1:0] pin_change_flags,
  output logic pin_change_irq,
  output module_disable_pkg::disable_bus_t disables,
  output logic pin_select_off_sync,
  output logic peripheral_clk_gate
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [7:0] dis0;
  logic [7:0] dis1;
  logic [7:0] dis2;
  logic [7:0] dis3;
  logic [7:0] dis4;
  logic [7:0] dis5;
  logic [7:0] irq_en0;
  logic [7:0] mask2;
  logic wr;
  logic rd;
  logic hit;
  logic [7:0] wbyte;
  logic [7:0] next_rdata;
  logic wr_dis0;
  logic wr_dis1;
  logic wr_dis2;
  logic wr_dis3;
  logic wr_dis4;
  logic wr_dis5;
  logic wr_irq;

  // Smaller variant loses the comparator-two bit entirely
  assign mask2 = LARGE_VARIANT ? module_disable_pkg::MASK_DIS2_LARGE
                               : module_disable_pkg::MASK_DIS2_SMALL;

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // Write lands on the access edge, the one at which the master sees pready
  assign wr = psel && penable && pready && pwrite && hit && pstrb[0];
  assign wr_dis0 = wr && (paddr == module_disable_pkg::ADDR_DIS0);
  assign wr_dis1 = wr && (paddr == module_disable_pkg::ADDR_DIS1);
  assign wr_dis2 = wr && (paddr == module_disable_pkg::ADDR_DIS2);
  assign wr_dis3 = wr && (paddr == module_disable_pkg::ADDR_DIS3);
  assign wr_dis4 = wr && (paddr == module_disable_pkg::ADDR_DIS4);
  assign wr_dis5 = wr && (paddr == module_disable_pkg::ADDR_DIS5);
  assign wr_irq = wr && (paddr == module_disable_pkg::ADDR_IRQ_EN0);
  assign rd = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  always_comb begin
    hit = 1'b1;
    next_rdata = 8'h00;
    case (paddr)
      module_disable_pkg::ADDR_DIS0: next_rdata = dis0;
      module_disable_pkg::ADDR_DIS1: next_rdata = dis1;
      module_disable_pkg::ADDR_DIS2: next_rdata = dis2;
      module_disable_pkg::ADDR_DIS3: next_rdata = dis3;
      module_disable_pkg::ADDR_DIS4: next_rdata = dis4;
      module_disable_pkg::ADDR_DIS5: next_rdata = dis5;
      module_disable_pkg::ADDR_IRQ_EN0: next_rdata = irq_en0;
      module_disable_pkg::ADDR_PC_STATUS: begin
        // Pin-change flags read zero while that module is held off
        next_rdata = disables.pin_change_off ? 8'h00
                                             : {7'h00, |pin_change_flags};
      end
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register storage, one block per register
  // ----------------------------------------------------------------
  // Unimplemented bits are masked on the way in, so reads need no mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis0 <= module_disable_pkg::RESET_DIS;
    end else if (wr_dis0) begin
      dis0 <= wbyte & module_disable_pkg::MASK_DIS0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis1 <= module_disable_pkg::RESET_DIS;
    end else if (wr_dis1) begin
      dis1 <= wbyte & module_disable_pkg::MASK_DIS1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis2 <= module_disable_pkg::RESET_DIS;
    end else if (wr_dis2) begin
      dis2 <= wbyte & mask2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis3 <= module_disable_pkg::RESET_DIS;
    end else if (wr_dis3) begin
      dis3 <= wbyte & module_disable_pkg::MASK_DIS3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis4 <= module_disable_pkg::RESET_DIS;
    end else if (wr_dis4) begin
      dis4 <= wbyte & module_disable_pkg::MASK_DIS4;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis5 <= module_disable_pkg::RESET_DIS;
    end else if (wr_dis5) begin
      dis5 <= wbyte & module_disable_pkg::MASK_DIS5;
    end
  end

  // Master enable lives here; only its one bit is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en0 <= 8'h00;
    end else if (wr_irq) begin
      irq_en0 <= wbyte & module_disable_pkg::MASK_IRQ_EN0;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Every access gets its answer in the first access cycle, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Unmapped addresses are refused rather than silently ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !hit;
    end
  end

  // Read data captured at setup; writes show zero so nothing stale leaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      if (rd) begin
        prdata <= {24'h00_0000, next_rdata};
      end else if (psel && !penable) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered disable levels
  // ----------------------------------------------------------------
  // One stored one per module means held in reset with clocks frozen
  // Levels follow the stored bits one clock late, so gating never glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disables.sysclk_net_off <= 1'b0;
      disables.vref_off <= 1'b0;
      disables.nonvolatile_off <= 1'b0;
      disables.clock_ref_out_off <= 1'b0;
      disables.pin_change_off <= 1'b0;
    end else begin
      disables.sysclk_net_off <= dis0[module_disable_pkg::B0_SYSCLK];
      disables.vref_off <= dis0[module_disable_pkg::B0_VREF];
      disables.nonvolatile_off <= dis0[module_disable_pkg::B0_NVM];
      disables.clock_ref_out_off <= dis0[module_disable_pkg::B0_CLKREF];
      disables.pin_change_off <= dis0[module_disable_pkg::B0_PINCHG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disables.num_osc_off <= 1'b0;
      disables.timer_c_off <= 1'b0;
      disables.timer_b_off <= 1'b0;
      disables.timer_a_off <= 1'b0;
    end else begin
      disables.num_osc_off <= dis1[module_disable_pkg::B1_NUMOSC];
      disables.timer_c_off <= dis1[module_disable_pkg::B1_TIMER_C];
      disables.timer_b_off <= dis1[module_disable_pkg::B1_TIMER_B];
      disables.timer_a_off <= dis1[module_disable_pkg::B1_TIMER_A];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disables.dig_to_analog_off <= 1'b0;
      disables.analog_to_dig_off <= 1'b0;
      disables.comparator_b_off <= 1'b0;
      disables.comparator_a_off <= 1'b0;
      disables.zero_cross_off <= 1'b0;
    end else begin
      disables.dig_to_analog_off <= dis2[module_disable_pkg::B2_DAC];
      disables.analog_to_dig_off <= dis2[module_disable_pkg::B2_ADC];
      disables.comparator_b_off <= dis2[module_disable_pkg::B2_CMP_B];
      disables.comparator_a_off <= dis2[module_disable_pkg::B2_CMP_A];
      disables.zero_cross_off <= dis2[module_disable_pkg::B2_ZCD];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disables.modulator_off <= 4'h0;
      disables.capture_unit_off <= 2'h0;
    end else begin
      disables.modulator_off <= dis3[5:2];
      disables.capture_unit_off <= dis3[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disables.async_serial_off <= 1'b0;
      disables.sync_serial_off <= 1'b0;
      disables.waveform_gen_off <= 1'b0;
    end else begin
      disables.async_serial_off <= dis4[module_disable_pkg::B4_ASYNC];
      disables.sync_serial_off <= dis4[module_disable_pkg::B4_SYNC];
      disables.waveform_gen_off <= dis4[module_disable_pkg::B4_WAVE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disables.logic_cell_off <= 4'h0;
    end else begin
      disables.logic_cell_off <= dis5[4:1];
    end
  end

  // ----------------------------------------------------------------
  // Peripheral clock network and input selection
  // ----------------------------------------------------------------
  // Gate reads closed during reset and opens at the first edge after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_clk_gate <= 1'b0;
    end else begin
      // Clock gate open only while the network bit is clear
      peripheral_clk_gate <= !dis0[module_disable_pkg::B0_SYSCLK];
    end
  end

  // One shared level: the selection logic cannot tell modules apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_select_off_sync <= 1'b0;
    end else begin
      // Input selection is cut whenever any selectable-input module is off
      pin_select_off_sync <= |{dis1[2:0], dis3[1:0], dis4[6], dis4[4], dis4[0], dis5[4:1],
                               dis2[5]};
    end
  end

  // ----------------------------------------------------------------
  // Pin-change detection and master gate
  // ----------------------------------------------------------------
  logic [module_disable_pkg::PIN_COUNT-1:0] pin_prev;
  logic [module_disable_pkg::PIN_COUNT-1:0] edge_hit;

  assign edge_hit = (rise_enable & pin_in & ~pin_prev)
                  | (fall_enable & ~pin_in & pin_prev);

  // Previous level tracks the pin even while off, so re-enable is quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  // Disabled unit is held in reset: flags cleared, edges ignored
  for (genvar g = 0; g < module_disable_pkg::PIN_COUNT; g++) begin : g_pin_flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_change_flags[g] <= 1'b0;
      end else if (dis0[module_disable_pkg::B0_PINCHG]) begin
        pin_change_flags[g] <= 1'b0;
      end else if (edge_hit[g]) begin
        // New edge wins over a clear in the same cycle
        pin_change_flags[g] <= 1'b1;
      end else if (flag_clear[g]) begin
        pin_change_flags[g] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt master gate
  // ----------------------------------------------------------------
  // Flags keep collecting while the gate is shut; opening it fires one clock after the enable lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_irq <= 1'b0;
    end else begin
      pin_change_irq <= irq_en0[module_disable_pkg::IRQ_EN0_PC_BIT]
                        && (|pin_change_flags);
    end
  end

endmodule // module_disable

// File: common/module_disable_pkg.sv
// Package: register map, field positions and carriers for the module-disable bank
package module_disable_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_DIS0 = 12'h000;
  localparam logic [11:0] ADDR_DIS1 = 12'h004;
  localparam logic [11:0] ADDR_DIS2 = 12'h008;
  localparam logic [11:0] ADDR_DIS3 = 12'h00c;
  localparam logic [11:0] ADDR_DIS4 = 12'h010;
  localparam logic [11:0] ADDR_DIS5 = 12'h014;
  localparam logic [11:0] ADDR_IRQ_EN0 = 12'h018;
  localparam logic [11:0] ADDR_PC_STATUS = 12'h01c;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_DIS0 = 8'hc7;
  localparam logic [7:0] MASK_DIS1 = 8'h87;
  localparam logic [7:0] MASK_DIS2_LARGE = 8'h67;
  localparam logic [7:0] MASK_DIS2_SMALL = 8'h63;
  localparam logic [7:0] MASK_DIS3 = 8'h3f;
  localparam logic [7:0] MASK_DIS4 = 8'h51;
  localparam logic [7:0] MASK_DIS5 = 8'h1e;
  localparam logic [7:0] RESET_DIS = 8'h00;
  localparam logic [7:0] MASK_IRQ_EN0 = 8'h10;
  localparam int IRQ_EN0_PC_BIT = 4;

  // Bit positions in the disable registers
  localparam int B0_SYSCLK = 7;
  localparam int B0_VREF = 6;
  localparam int B0_NVM = 2;
  localparam int B0_CLKREF = 1;
  localparam int B0_PINCHG = 0;
  localparam int B1_NUMOSC = 7;
  localparam int B1_TIMER_C = 2;
  localparam int B1_TIMER_B = 1;
  localparam int B1_TIMER_A = 0;
  localparam int B2_DAC = 6;
  localparam int B2_ADC = 5;
  localparam int B2_CMP_B = 2;
  localparam int B2_CMP_A = 1;
  localparam int B2_ZCD = 0;
  localparam int B4_ASYNC = 6;
  localparam int B4_SYNC = 4;
  localparam int B4_WAVE = 0;

  localparam int PIN_COUNT = 12;

  // ----------------------------------------------------------------
  // Carrier of the per-module disable levels
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sysclk_net_off;
    logic vref_off;
    logic nonvolatile_off;
    logic clock_ref_out_off;
    logic pin_change_off;
    logic num_osc_off;
    logic timer_c_off;
    logic timer_b_off;
    logic timer_a_off;
    logic dig_to_analog_off;
    logic analog_to_dig_off;
    logic comparator_b_off;
    logic comparator_a_off;
    logic zero_cross_off;
    logic [3:0] modulator_off;
    logic [1:0] capture_unit_off;
    logic async_serial_off;
    logic sync_serial_off;
    logic waveform_gen_off;
    logic [3:0] logic_cell_off;
  } disable_bus_t;

endpackage

// File: test/module_disable_monitor.sv
// Concurrent checks on the module-disable bank ports
`timescale 1ns/1ps
module module_disable_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [module_disable_pkg::PIN_COUNT-1:0] pin_change_flags,
  input wire logic pin_change_irq,
  input wire module_disable_pkg::disable_bus_t disables,
  input wire logic peripheral_clk_gate
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply malformed");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_dis_after_write: assert property (!$stable(disables) |->
    $past(psel && penable && pwrite && pready, 2))
    else $error("disables moved without a write");
  a_write_lands: assert property (psel && penable && pready && pwrite && pstrb[0] &&
    paddr == module_disable_pkg::ADDR_DIS3 |-> ##2
    disables.capture_unit_off == $past(pwdata[1:0], 2) &&
    disables.modulator_off == $past(pwdata[5:2], 2))
    else $error("disable bank 3 not applied");
  a_flags_held_off: assert property (disables.pin_change_off |-> pin_change_flags == '0)
    else $error("flags alive while unit off");
  a_irq_has_flag: assert property (pin_change_irq |-> |pin_change_flags || $past(|pin_change_flags))
    else $error("irq without flag");
  a_gate_stops: assert property (disables.sysclk_net_off |-> !peripheral_clk_gate)
    else $error("clock network still running");
  cover property (pslverr);
  cover property (pin_change_irq);
  cover property (disables.sysclk_net_off);
endmodule // module_disable_monitor

bind module_disable module_disable_monitor module_disable_monitor_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_change_flags(pin_change_flags), .pin_change_irq(pin_change_irq),
  .disables(disables), .peripheral_clk_gate(peripheral_clk_gate));

// File: test/module_disable_tb.sv
// Self-checking bench for the module-disable bank
`timescale 1ns/1ps
module module_disable_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq, sel_off, gate;
  logic [11:0] pin_in = 12'h0, rise = 12'h0, fall = 12'h0, clr = 12'h0, flags, p;
  module_disable_pkg::disable_bus_t dis;
  int error_cnt = 0, tests_run = 0, cycles = 0;
  logic [31:0] seed = 32'he01d;
  logic [7:0] m [6];
  localparam logic [7:0] MSK [6] = '{8'hc7, 8'h87, 8'h67, 8'h3f, 8'h51, 8'h1e};

  always #12.5 pclk = ~pclk;

  module_disable module_disable_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .rise_enable(rise), .fall_enable(fall), .flag_clear(clr), .pin_change_flags(flags),
    .pin_change_irq(irq), .disables(dis), .pin_select_off_sync(sel_off),
    .peripheral_clk_gate(gate));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [26:0] exp_dis();
    return {m[0][7:6], m[0][2:0], m[1][7], m[1][2:0], m[2][6:5], m[2][2:0], m[3][5:0],
      m[4][6], m[4][4], m[4][0], m[5][4:1]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input int i, input logic [7:0] d);
    apb(1'b1, 12'(i * 4), {24'h0, d});
    m[i] = d & MSK[i];
    repeat (2) @(negedge pclk);
    chk(32'(dis), 32'(exp_dis()));
    chk({31'h0, gate}, {31'h0, ~m[0][7]});
    chk({31'h0, sel_off}, {31'h0, |{m[1][2:0], m[2][5], m[3][1:0], m[4][6], m[4][4], m[4][0],
      m[5][4:1]}});
  endtask
  task automatic rreg(input int i);
    apb(1'b0, 12'(i * 4), 32'h0);
    chk(rd, {24'h0, m[i]});
  endtask
  task automatic summarize();
    $display("counts: %0d compared, %0d mismatched", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(dis), 32'h0);
    for (int i = 0; i < 6; i++) rreg(i);
    for (int i = 0; i < 6; i++) wreg(i, 8'hff);
    for (int i = 0; i < 6; i++) rreg(i);
    for (int k = 0; k < 30; k++) begin
      wreg(int'(rnd() % 6), 8'(rnd()));
      rreg(k % 6);
    end
    $display("test map done");
    apb(1'b1, 12'h040, 32'hff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, {24'h0, ~m[0]});
    pstrb <= 4'hf;
    for (int i = 0; i < 6; i++) rreg(i);
    wreg(0, 8'h80);
    repeat (2) @(negedge pclk);
    chk({31'h0, gate}, 32'h0);
    $display("test refusal done");
    wreg(0, 8'h00);
    apb(1'b1, 12'h018, 32'h10);
    p = 12'(rnd()) | 12'h001;
    rise <= 12'hfff;
    pin_in <= p;
    repeat (4) @(negedge pclk);
    chk(flags, p);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 12'h018, 32'h00);
    clr <= 12'hfff;
    fall <= 12'hfff;
    @(posedge pclk);
    clr <= 12'h000;
    pin_in <= 12'h000;
    repeat (4) @(negedge pclk);
    chk(flags, p);
    chk({31'h0, irq}, 32'h0);
    wreg(0, 8'h01);
    repeat (2) @(negedge pclk);
    chk(flags, 12'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, 32'h0);
    $display("test pin change done");
    wreg(3, 8'h3f);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    foreach (m[i]) m[i] = 8'h00;
    chk(32'(dis), 32'h0);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rreg(i);
    $display("test reset done");
    summarize();
  end
endmodule // module_disable_tb
